/* hdl/legacy_link_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the legacy serial link.
// Assumes: Included by its bare name wherever these figures are needed.
// Notes: Bit indices count the rising serial clock edges of one transaction from zero.
`ifndef LEGACY_LINK_CFG_SVH
`define LEGACY_LINK_CFG_SVH

// ==========================================================
// Serial frame positions
`define LINK_BIT_DIR 4'h1
`define LINK_BIT_TGT 4'h2
`define LINK_BIT_FIRST_DATA 4'h3
`define LINK_BIT_LAST_DATA 4'hA
`define LINK_BIT_STATUS 4'hB
`define LINK_BIT_GAP 4'hC
`define LINK_BIT_END 4'hD

// ==========================================================
// Status byte fields and hold byte reset value
`define STAT_RXF 0
`define STAT_TXE 1
`define STAT_RXIE 4
`define STAT_TXIE 5
`define DEV_BYTE_RESET 8'h00

// ==========================================================
// Controller timing and registers
`define HALF_PERIOD_CYCLES 6
`define MIN_HALF_PERIOD 4
`define REG_CMD 8'h00
`define REG_STATE 8'h04
`define REG_RESULT 8'h08
`define CMD_TGT 8
`define CMD_DIR 9
`define CMD_RETRY 10

`endif

/* hdl/legacy_link_pkg.sv */
// Purpose: Types shared by both ends of the legacy serial link.
// Assumes: Figures live in legacy_link_cfg.svh.
// Notes: State codes are written out.
package legacy_link_pkg;

  typedef enum logic [1:0]
  {
    DEV_IDLE = 2'b00,
    DEV_BUSY = 2'b01,
    DEV_GAP = 2'b10
  } dev_phase_e;

  typedef enum logic [0:0]
  {
    MST_IDLE = 1'b0,
    MST_RUN = 1'b1
  } mst_phase_e;

endpackage

/* hdl/legacy_link_if.sv */
// Purpose: Four wires between the serial master and the legacy slave.
// Assumes: All wires are plain one-way signals.
// Notes: Select is active high on this link.
`timescale 1ns/100ps
interface legacy_link_if;
  logic sclk;
  logic ss;
  logic mosi;
  logic miso;

  modport device
  (
    input sclk,
    input ss,
    input mosi,
    output miso
  );

  modport master
  (
    output sclk,
    output ss,
    output mosi,
    input miso
  );
endinterface

/* hdl/legacy_link_device.sv */
// Purpose: Slave end of the legacy four-wire link with one-byte receive and transmit holds.
// Assumes: core_clk is much faster than the serial clock; all link pins are asynchronous.
// Notes: Each serial clock rise is found three core cycles late, after the synchronisers.
`timescale 1ns/100ps
`include "legacy_link_cfg.svh"

module legacy_link_device
(
  input wire logic core_clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  legacy_link_if.device link, // Serial link toward the master.
  output logic [7:0] rxData, // Byte held in the receive buffer.
  output logic rxFull, // Receive buffer holds an unread byte.
  input wire logic rxPop, // Pulse: user has taken the receive byte.
  input wire logic [7:0] txData, // Byte offered to the transmit buffer.
  input wire logic txPush, // Pulse: load txData when the buffer is empty.
  output logic txEmpty, // Transmit buffer has no new byte.
  input wire logic rxFullIrqEnable, // Reported in status byte bit 4.
  input wire logic txEmptyIrqEnable // Reported in status byte bit 5.
);

  // ==========================================================
  // State
  typedef struct packed
  {
    logic sclkS1;
    logic sclkS2;
    logic sclkPrev;
    logic ssS1;
    logic ssS2;
    logic mosiS1;
    logic mosiS2;
    legacy_link_pkg::dev_phase_e phase;
    logic [3:0] bitCnt;
    logic dir;
    logic tgt;
    logic statBit;
    logic [7:0] shift;
    logic miso;
    logic [7:0] rxByte;
    logic rxFull;
    logic [7:0] txByte;
    logic txEmpty;
  } dev_state_s;

  dev_state_s st_q;
  dev_state_s st_d;

  // ==========================================================
  // Next state
  always_comb
  begin
    logic rise;
    logic [7:0] statusByte;
    logic [7:0] loadByte;
    logic [7:0] wrByte;
    rise = 1'b0;
    statusByte = 8'h00;
    loadByte = 8'h00;
    wrByte = 8'h00;
    st_d = st_q;

    // Only the second stage of each synchroniser is looked at.
    st_d.sclkS1 = link.sclk;
    st_d.sclkS2 = st_q.sclkS1;
    st_d.sclkPrev = st_q.sclkS2;
    st_d.ssS1 = link.ss;
    st_d.ssS2 = st_q.ssS1;
    st_d.mosiS1 = link.mosi;
    st_d.mosiS2 = st_q.mosiS1;
    rise = st_q.sclkS2 & ~st_q.sclkPrev;

    statusByte[`STAT_RXF] = st_q.rxFull;
    statusByte[`STAT_TXE] = st_q.txEmpty;
    statusByte[`STAT_RXIE] = rxFullIrqEnable;
    statusByte[`STAT_TXIE] = txEmptyIrqEnable;
    wrByte = {st_q.shift[6:0], st_q.mosiS2};

    // User side of the holds; link updates below come later and win.
    if (rxPop)
    begin
      st_d.rxFull = 1'b0;
    end
    if (txPush && st_q.txEmpty)
    begin
      st_d.txByte = txData;
      st_d.txEmpty = 1'b0;
    end

    if (rise)
    begin
      if (!st_q.ssS2)
      begin
        // Nothing is committed before the last data bit, so dropping out is clean.
        st_d.phase = legacy_link_pkg::DEV_IDLE;
        st_d.miso = 1'b0;
      end
      else
      begin
        unique case (st_q.phase)
          legacy_link_pkg::DEV_IDLE:
          begin
            if (st_q.mosiS2)
            begin
              st_d.phase = legacy_link_pkg::DEV_BUSY;
              st_d.bitCnt = `LINK_BIT_DIR;
            end
          end
          legacy_link_pkg::DEV_GAP:
          begin
            // Waits for a rise with select low before a new start.
            st_d.phase = legacy_link_pkg::DEV_GAP;
          end
          legacy_link_pkg::DEV_BUSY:
          begin
            st_d.bitCnt = 4'(st_q.bitCnt + 4'h1);
            if (st_q.bitCnt == `LINK_BIT_DIR)
            begin
              st_d.dir = st_q.mosiS2;
            end
            else if (st_q.bitCnt == `LINK_BIT_TGT)
            begin
              st_d.tgt = st_q.mosiS2;
              st_d.shift = 8'h00;
              if (st_q.dir)
              begin
                if (st_q.mosiS2)
                begin
                  loadByte = statusByte;
                  st_d.statBit = 1'b0;
                end
                else
                begin
                  loadByte = st_q.txByte;
                  st_d.statBit = st_q.txEmpty;
                end
                st_d.shift = loadByte;
                st_d.miso = loadByte[7];
              end
            end
            else if (st_q.bitCnt < `LINK_BIT_LAST_DATA)
            begin
              if (st_q.dir)
              begin
                st_d.miso = st_q.shift[6];
                st_d.shift = {st_q.shift[6:0], 1'b0};
              end
              else
              begin
                st_d.shift = wrByte;
              end
            end
            else if (st_q.bitCnt == `LINK_BIT_LAST_DATA)
            begin
              if (st_q.dir)
              begin
                st_d.miso = st_q.statBit;
                // A byte pushed after the load was never sent, so only a byte sent as new is removed.
                if (!st_q.tgt && !st_q.statBit)
                begin
                  st_d.txEmpty = 1'b1;
                end
              end
              else if (st_q.tgt)
              begin
                st_d.miso = 1'b1;
              end
              else if (st_q.rxFull)
              begin
                st_d.miso = 1'b1;
              end
              else
              begin
                st_d.rxByte = wrByte;
                st_d.rxFull = 1'b1;
                st_d.miso = 1'b0;
              end
            end
            else
            begin
              // Status bit has been sampled at this rise; release it.
              st_d.miso = 1'b0;
              if (st_q.dir && st_q.tgt)
              begin
                st_d.phase = legacy_link_pkg::DEV_IDLE;
              end
              else
              begin
                st_d.phase = legacy_link_pkg::DEV_GAP;
              end
            end
          end
          default:
          begin
            st_d.phase = legacy_link_pkg::DEV_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= '{
        phase: legacy_link_pkg::DEV_IDLE,
        rxByte: `DEV_BYTE_RESET,
        txByte: `DEV_BYTE_RESET,
        txEmpty: 1'b1,
        default: '0
      };
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign link.miso = st_q.miso;
  assign rxData = st_q.rxByte;
  assign rxFull = st_q.rxFull;
  assign txEmpty = st_q.txEmpty;

endmodule

/* hdl/legacy_link_master.sv */
// Purpose: Serial master end of the legacy link, ordered over APB.
// Assumes: The slave answers within six core cycles of each serial clock rise.
// Notes: The serial clock is made here by a divider of core_clk.
`timescale 1ns/100ps
`include "legacy_link_cfg.svh"

module legacy_link_master
#(
  parameter int HALF_CYCLES = `HALF_PERIOD_CYCLES // Core cycles per serial clock half.
)
(
  input wire logic core_clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  legacy_link_if.master link // Serial link toward the slave.
);

  localparam int DW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;

  if (HALF_CYCLES < `MIN_HALF_PERIOD)
  begin : g_check
    $error("HALF_CYCLES too small for the slave answer latency");
  end

  // ==========================================================
  // State
  typedef struct packed
  {
    legacy_link_pkg::mst_phase_e phase;
    logic misoS1;
    logic misoS2;
    logic sclk;
    logic ss;
    logic mosi;
    logic [DW-1:0] divCnt;
    logic [3:0] bitIdx;
    logic [11:0] frame;
    logic launch;
    logic retry;
    logic [7:0] rxShift;
    logic statBit;
    logic done;
    logic [7:0] resByte;
    logic resStat;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mst_state_s;

  mst_state_s st_q;
  mst_state_s st_d;

  // ==========================================================
  // Next state
  always_comb
  begin
    st_d = st_q;
    st_d.misoS1 = link.miso;
    st_d.misoS2 = st_q.misoS1;
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    st_d.launch = 1'b0;

    // Register reads are prepared in the setup cycle and shown in the access cycle.
    if (psel && !penable)
    begin
      st_d.pready = 1'b1;
      st_d.prdata = 32'h0000_0000;
      if (paddr == `REG_STATE)
      begin
        st_d.prdata = {30'h0, st_q.done, st_q.phase == legacy_link_pkg::MST_RUN};
      end
      else if (paddr == `REG_RESULT)
      begin
        // Each result belongs to its own transaction only.
        st_d.prdata = {23'h0, st_q.resStat, st_q.resByte};
      end
      else if (paddr != `REG_CMD)
      begin
        st_d.pslverr = 1'b1;
      end
    end

    if (psel && penable && st_q.pready && pwrite && paddr == `REG_CMD
        && st_q.phase == legacy_link_pkg::MST_IDLE)
    begin
      st_d.frame = {1'b1, pwdata[`CMD_DIR], pwdata[`CMD_TGT], pwdata[7:0], 1'b0};
      st_d.retry = pwdata[`CMD_RETRY];
      st_d.done = 1'b0;
      st_d.phase = legacy_link_pkg::MST_RUN;
      st_d.ss = 1'b1;
      st_d.mosi = 1'b1;
      st_d.sclk = 1'b0;
      st_d.divCnt = '0;
      st_d.bitIdx = 4'h0;
    end
    else if (st_q.phase == legacy_link_pkg::MST_RUN)
    begin
      // Bits change one core cycle after a rise, so the slave samples the old value.
      if (st_q.launch)
      begin
        if (st_q.bitIdx <= `LINK_BIT_STATUS)
        begin
          st_d.mosi = st_q.frame[`LINK_BIT_STATUS - st_q.bitIdx];
        end
        else if (st_q.bitIdx == `LINK_BIT_GAP)
        begin
          // Select held high up to here, then low until a retry frame or the next command raises it.
          st_d.ss = 1'b0;
          st_d.mosi = 1'b0;
        end
      end
      st_d.divCnt = DW'(st_q.divCnt + 1'b1);
      if (st_q.divCnt == DW'(HALF_CYCLES - 1))
      begin
        st_d.divCnt = '0;
        st_d.sclk = ~st_q.sclk;
        if (!st_q.sclk)
        begin
          st_d.bitIdx = 4'(st_q.bitIdx + 4'h1);
          st_d.launch = 1'b1;
          if (st_q.bitIdx >= `LINK_BIT_FIRST_DATA && st_q.bitIdx <= `LINK_BIT_LAST_DATA)
          begin
            st_d.rxShift = {st_q.rxShift[6:0], st_q.misoS2};
          end
          else if (st_q.bitIdx == `LINK_BIT_STATUS)
          begin
            st_d.statBit = st_q.misoS2;
          end
        end
        else if (st_q.bitIdx == `LINK_BIT_END)
        begin
          st_d.resByte = st_q.rxShift;
          st_d.resStat = st_q.statBit;
          if (st_q.retry && st_q.statBit)
          begin
            // Same frame again: rejected write or old read data.
            st_d.ss = 1'b1;
            st_d.mosi = 1'b1;
            st_d.bitIdx = 4'h0;
          end
          else
          begin
            st_d.phase = legacy_link_pkg::MST_IDLE;
            st_d.done = 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= '{phase: legacy_link_pkg::MST_IDLE, default: '0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign link.sclk = st_q.sclk;
  assign link.ss = st_q.ss;
  assign link.mosi = st_q.mosi;
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;

endmodule

/* tb/legacy_link_checker.sv */
// Purpose: Assertions on the four wires between the two link ends.
// Assumes: Both ends run on core_clk and launch the wires from flops.
// Notes: A frame is followed from its start rise to its select-low rise.
`timescale 1ns/100ps
module legacy_link_checker
(
  input wire logic core_clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic sclk, // Serial clock.
  input wire logic ss, // Select, active high.
  input wire logic mosi, // Master data.
  input wire logic miso // Slave data.
);
  logic sclkPrev_q;
  logic act_q;
  logic [3:0] idx_q;
  logic dir_q;
  logic tgt_q;
  logic rise;

  // ==========================================================
  // Frame tracking
  assign rise = sclk && !sclkPrev_q;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclkPrev_q <= 1'b0;
      act_q <= 1'b0;
      idx_q <= 4'h0;
      dir_q <= 1'b0;
      tgt_q <= 1'b0;
    end
    else
    begin
      sclkPrev_q <= sclk;
      if (rise && !act_q && ss && mosi)
      begin
        act_q <= 1'b1;
        idx_q <= 4'h0;
      end
      else if (rise && act_q)
      begin
        idx_q <= idx_q + 4'h1;
        act_q <= (idx_q != 4'hB);
        if (idx_q == 4'h0)
          dir_q <= mosi;
        if (idx_q == 4'h1)
          tgt_q <= mosi;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  start_bit_a: assert property (rise && !act_q && ss |-> mosi)
    else $error("Frame opened without a start bit.");
  select_held_a: assert property (rise && act_q && idx_q < 4'hB |-> ss)
    else $error("Select low inside a frame.");
  select_drop_a: assert property (rise && act_q && idx_q == 4'hB |-> !ss)
    else $error("Select high at the turnaround rise.");
  status_zero_a: assert property (rise && act_q && idx_q == 4'hA && dir_q && tgt_q |-> !miso)
    else $error("Status read ended with a nonzero bit.");
  unused_bits_a: assert property (rise && act_q && dir_q && tgt_q
    && idx_q inside {4'h2, 4'h3, 4'h6, 4'h7} |-> !miso)
    else $error("Unused status byte bit set.");
  target_write_a: assert property (rise && act_q && idx_q == 4'hA && !dir_q && tgt_q |-> miso)
    else $error("Write to the status target not refused.");
  mosi_launch_a: assert property ($changed(mosi) && ss && $past(ss)
    |-> $past(sclk) && !$past(sclk, 2))
    else $error("Master data moved off a clock rise.");
  // The slave moves miso three core cycles after the rise, after its synchronisers.
  miso_launch_a: assert property ($changed(miso) |-> $past(sclk, 3) && !$past(sclk, 4))
    else $error("Slave data moved off a clock rise.");
  idle_quiet_a: assert property (!act_q && !ss |-> !miso)
    else $error("Slave drives data while idle.");

  cover property (rise && act_q && idx_q == 4'hA && dir_q && tgt_q);
  cover property (rise && act_q && idx_q == 4'hA && dir_q && !tgt_q && !miso);
  cover property (rise && act_q && idx_q == 4'hA && !dir_q && !tgt_q && miso);
endmodule

/* tb/tb.sv */
// Purpose: Self-checking bench of both link ends, ordered over APB.
// Assumes: The master divider stays at its default.
// Notes: Random bytes come from an xorshift with a fixed seed.
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] rxData;
  logic rxFull;
  logic txEmpty;
  logic rxPop = 1'b0;
  logic txPush = 1'b0;
  logic [7:0] txData = 8'h00;
  logic rie = 1'b0;
  logic tie = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h42;
  logic [31:0] res;
  logic err;
  logic [7:0] b;

  legacy_link_if lnk();
  legacy_link_master legacy_link_master_inst (.core_clk(core_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
  legacy_link_device legacy_link_device_inst (.core_clk(core_clk), .reset_n(reset_n),
    .link(lnk), .rxData(rxData), .rxFull(rxFull), .rxPop(rxPop), .txData(txData),
    .txPush(txPush), .txEmpty(txEmpty), .rxFullIrqEnable(rie), .txEmptyIrqEnable(tie));
  legacy_link_checker legacy_link_checker_inst (.core_clk(core_clk), .reset_n(reset_n),
    .sclk(lnk.sclk), .ss(lnk.ss), .mosi(lnk.mosi), .miso(lnk.miso));

  // ==========================================================
  // Clock, timeout and helpers
  always #5 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end

  task results;
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  function logic [7:0] stsByte(input logic rf, input logic te, input logic ri, input logic ti);
    return {2'b00, ti, ri, 2'b00, te, rf};
  endfunction

  task chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    res = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Orders one transaction and waits for done, leaving the result word in res.
  task automatic txn(input logic d, input logic t, input logic r, input logic [7:0] v);
    int i;
    apb(1'b1, 8'h00, {21'h0, r, d, t, v});
    res = 32'h0;
    for (i = 0; i < 600 && res[1] !== 1'b1; i++)
      apb(1'b0, 8'h04, 32'h0);
    chk({8'h00, res[1]}, 9'h001);
    apb(1'b0, 8'h08, 32'h0);
  endtask

  task pulsePop;
    @(posedge core_clk);
    rxPop <= 1'b1;
    @(posedge core_clk);
    rxPop <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      b = (k == 0) ? 8'h80 : xs();
      txn(1'b0, 1'b0, 1'b0, b);
      chk({8'h00, res[8]}, 9'h000);
      chk({1'b0, rxData}, {1'b0, b});
      if (k < 2)
        pulsePop();
    end
    txn(1'b0, 1'b0, 1'b0, ~b);
    chk({8'h00, res[8]}, 9'h001);
    chk({1'b0, rxData}, {1'b0, b});
    for (int k = 0; k < 4; k++)
    begin
      rie <= k[0];
      tie <= k[1];
      txn(1'b1, 1'b1, 1'b0, xs());
      chk(res[8:0], {1'b0, stsByte(1'b1, 1'b1, k[0], k[1])});
    end
    pulsePop();
    txn(1'b0, 1'b1, 1'b0, xs());
    chk({8'h00, res[8]}, 9'h001);
    chk({8'h00, rxFull}, 9'h000);
    txn(1'b1, 1'b0, 1'b0, 8'h00);
    chk({8'h00, res[8]}, 9'h001);
    b = xs();
    @(posedge core_clk);
    txData <= b;
    txPush <= 1'b1;
    @(posedge core_clk);
    txPush <= 1'b0;
    txn(1'b1, 1'b0, 1'b0, 8'h00);
    chk(res[8:0], {1'b0, b});
    chk({8'h00, txEmpty}, 9'h001);
    txn(1'b1, 1'b0, 1'b0, 8'h00);
    chk(res[8:0], {1'b1, b});
    txn(1'b0, 1'b0, 1'b0, 8'h01);
    chk({8'h00, res[8]}, 9'h000);
    b = xs();
    fork
      txn(1'b0, 1'b0, 1'b1, b);
      begin
        repeat (400) @(posedge core_clk);
        pulsePop();
      end
    join
    chk({8'h00, res[8]}, 9'h000);
    chk({1'b0, rxData}, {1'b0, b});
    // Reads repeat on old data; the push lands inside a frame that already loaded the old byte.
    b = xs();
    fork
      txn(1'b1, 1'b0, 1'b1, 8'h00);
      begin
        repeat (400) @(posedge core_clk);
        txData <= b;
        txPush <= 1'b1;
        @(posedge core_clk);
        txPush <= 1'b0;
      end
    join
    chk(res[8:0], {1'b0, b});
    chk({8'h00, txEmpty}, 9'h001);
    apb(1'b0, 8'h0C, 32'h0);
    chk({8'h00, err}, 9'h001);
    chk(res[8:0], 9'h000);
    results();
  end
endmodule
